// ### logic/tqc_top.sv
// timer three with four capture channels behind an ahb-lite slave
`timescale 1ns/100ps
// Summary of operation
// [R1] one 16-bit counter, two byte registers
// [R2] source: every cycle or external falling edges
// [R3] run clear holds counter, no wrap flag
// [R4] mode bit picks period or four captures
// [R5] period match loads zero, sets wrap flag
// [R6] wrap flag sticky; enable gates request only
// [R7] period mode disables channel one captures; its prescaler still counts
// [R8] event: falling, rising, 4th or 16th rising
// [R9] event copies counter, latches capture flag
// [R10] capture request needs enable, peripheral, global
// [R11] software clears capture flags, reads never do
// [R12] select change keeps prescaler; reset clears
// [R13] capture watches pin even as port
// [R14] capture inputs synchronised before edge logic
// [R15] event on unread word sets master overrun
// [R16] both bytes read copies master, clears it
// [R17] four-capture mode wraps at all ones
// [R18] period register becomes capture one
// [R19] four pins, one per capture channel
// [R20] software reads low, high, then status
// [R21] select codes 00 fall 01 rise 10 11
// [R22] load marks unread; both reads mark read
module tqc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_count_clock_pin,
  input  wire logic [3:0]  capture_input_pin,
  output logic             timer_irq,
  output logic             capture_irq
);
  localparam int N = tqc_pkg::NUM_CH;

  logic [tqc_pkg::CTL_W-1:0] ctrl;
  logic [7:0]                evsel;
  logic [N-1:0]              capen;
  logic                      wrap_flag;
  logic [N-1:0]              cap_flag;
  logic [15:0]               count_q;
  logic [15:0]               cap_q [N];
  logic [N-1:0]              take;
  logic [N-1:0]              overrun;
  logic [N-1:0]              cap_lvl;
  logic [N-1:0]              rd_lo;
  logic [N-1:0]              rd_hi;
  logic                      ext_lvl;
  logic                      ext_prev;
  logic                      ext_fall;
  logic                      tick;
  logic                      quad;
  logic                      addr_ok;
  logic                      rd_req;
  logic                      wr_req;
  logic                      wr_act;
  logic [7:0]                wr_addr;
  logic                      wr_cnt;
  logic                      wrap_ev;
  logic [31:0]               next_rdata;
  logic [7:0]                ra;

  assign quad = ctrl[tqc_pkg::CTL_QUAD]; // [R4]
  assign ra   = haddr[7:0];

  // the low byte of the address decodes, the upper 24 bits must be zero; hsize is whole-word only
  assign addr_ok = (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
  assign rd_req  = hsel && hready && (htrans == tqc_pkg::HTRANS_NONSEQ)
                   && !hwrite;
  assign wr_req  = hsel && hready && (htrans == tqc_pkg::HTRANS_NONSEQ)
                   && hwrite;

  function automatic logic [7:0] cap_lo_off(input int i);
    cap_lo_off = tqc_pkg::OFF_CAP_LO + tqc_pkg::CAP_STRIDE * 8'(i);
  endfunction

  function automatic logic [7:0] cap_hi_off(input int i);
    cap_hi_off = tqc_pkg::OFF_CAP_HI + tqc_pkg::CAP_STRIDE * 8'(i);
  endfunction

  // pin synchronisers and capture channels
  tqc_sync u_ext_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (ext_count_clock_pin),
    .level   (ext_lvl)
  );

  for (genvar g = 0; g < N; g++)
  begin : g_ch
    tqc_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (capture_input_pin[g]), // [R13] [R19]
      .level   (cap_lvl[g])
    );
    tqc_chan u_chan (
      .hclk    (hclk),
      .hresetn (hresetn),
      .level   (cap_lvl[g]),
      .sel     (evsel[2*g +: 2]),
      .active  ((g == 0) ? quad : 1'b1), // [R7] [R18]
      .rd_lo   (rd_lo[g]),
      .rd_hi   (rd_hi[g]),
      .take    (take[g]),
      .overrun (overrun[g])
    );
  end

  // reads never clear capture flags, only bump the byte-read tracking
  always_comb
  begin
    rd_lo = '0;
    rd_hi = '0;
    for (int i = 0; i < N; i++)
    begin
      rd_lo[i] = rd_req && addr_ok && (ra == cap_lo_off(i)); // [R11]
      rd_hi[i] = rd_req && addr_ok && (ra == cap_hi_off(i));
    end
  end

  // external count clock: falling edge of the filtered level
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ext_prev <= 1'b0;
    else
      ext_prev <= ext_lvl;

  assign ext_fall = ext_prev & ~ext_lvl;
  assign tick = ctrl[tqc_pkg::CTL_RUN] &&
                (ctrl[tqc_pkg::CTL_SRC] ? ext_fall : 1'b1); // [R2] [R3]

  assign wr_cnt = wr_act && ((wr_addr == tqc_pkg::OFF_CNT_LO) ||
                             (wr_addr == tqc_pkg::OFF_CNT_HI));
  assign wrap_ev = tick && !wr_cnt &&
                   (quad ? (count_q == tqc_pkg::COUNT_TOP)   // [R17]
                         : (count_q == cap_q[0]));           // [R5]

  // bus address phase latch for writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_act  <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_act  <= wr_req && addr_ok;
      wr_addr <= ra;
    end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (addr_ok)
    begin
      unique case (ra)
        tqc_pkg::OFF_CTRL:   next_rdata[tqc_pkg::CTL_W-1:0] = ctrl;
        tqc_pkg::OFF_EVSEL:  next_rdata[7:0] = evsel;
        tqc_pkg::OFF_CAPEN:  next_rdata[N-1:0] = capen;
        tqc_pkg::OFF_FLAGS:  next_rdata[N:0] = {cap_flag, wrap_flag};
        tqc_pkg::OFF_OVR:    next_rdata[N-1:0] = overrun;
        tqc_pkg::OFF_CNT_LO: next_rdata[7:0] = count_q[7:0]; // [R1]
        tqc_pkg::OFF_CNT_HI: next_rdata[7:0] = count_q[15:8]; // [R1]
        default:
          for (int i = 0; i < N; i++)
          begin
            if (ra == cap_lo_off(i))
              next_rdata[7:0] = cap_q[i][7:0];
            if (ra == cap_hi_off(i))
              next_rdata[7:0] = cap_q[i][15:8];
          end
      endcase
    end
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_req)
      hrdata <= next_rdata;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl  <= tqc_pkg::RST_CTRL;
      evsel <= tqc_pkg::RST_EVSEL;
      capen <= '0;
    end
    else if (wr_act)
    begin
      if (wr_addr == tqc_pkg::OFF_CTRL)
        ctrl <= hwdata[tqc_pkg::CTL_W-1:0];
      if (wr_addr == tqc_pkg::OFF_EVSEL)
        evsel <= hwdata[7:0]; // [R12]
      if (wr_addr == tqc_pkg::OFF_CAPEN)
        capen <= hwdata[N-1:0];
    end

  // byte writes take priority over counting in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      count_q <= tqc_pkg::RST_COUNT;
    else if (wr_act && wr_addr == tqc_pkg::OFF_CNT_LO)
      count_q[7:0] <= hwdata[7:0]; // [R1]
    else if (wr_act && wr_addr == tqc_pkg::OFF_CNT_HI)
      count_q[15:8] <= hwdata[7:0]; // [R1]
    else if (wrap_ev)
      count_q <= 16'h0000; // [R5] [R17]
    else if (tick)
      count_q <= count_q + 16'h0001; // [R2]

  // flags: hardware set beats a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wrap_flag <= 1'b0;
    else if (wrap_ev)
      wrap_flag <= 1'b1; // [R5] [R6] [R17]
    else if (wr_act && wr_addr == tqc_pkg::OFF_FLAGS &&
             hwdata[tqc_pkg::FLG_WRAP])
      wrap_flag <= 1'b0; // [R6]

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cap_flag <= '0;
    else
      for (int i = 0; i < N; i++)
        if (take[i])
          cap_flag[i] <= 1'b1; // [R9]
        else if (wr_act && wr_addr == tqc_pkg::OFF_FLAGS &&
                 hwdata[tqc_pkg::FLG_CAP + i])
          cap_flag[i] <= 1'b0;

  // channel one doubles as period register, writable by software
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      for (int i = 0; i < N; i++)
        cap_q[i] <= 16'h0000;
    else
      for (int i = 0; i < N; i++)
        if (take[i])
          cap_q[i] <= count_q; // [R9] [R18]
        else if (i == 0 && wr_act && wr_addr == cap_lo_off(0))
          cap_q[i][7:0] <= hwdata[7:0];
        else if (i == 0 && wr_act && wr_addr == cap_hi_off(0))
          cap_q[i][15:8] <= hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      timer_irq   <= 1'b0;
      capture_irq <= 1'b0;
    end
    else
    begin
      timer_irq   <= wrap_flag && ctrl[tqc_pkg::CTL_WRAPEN]; // [R6]
      capture_irq <= (|(cap_flag & capen)) &&
                     ctrl[tqc_pkg::CTL_PERIPHERAL_IRQ_ENABLE] &&
                     !ctrl[tqc_pkg::CTL_GDIS]; // [R10]
    end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_hold;
    (!ctrl[tqc_pkg::CTL_RUN] && !wr_cnt) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) // [R3]
    else $error("counter moved while stopped");

  property p_stop_flag;
    (!ctrl[tqc_pkg::CTL_RUN] && !wrap_flag) |=> !wrap_flag;
  endproperty
  a_stop_flag: assert property (p_stop_flag) // [R3]
    else $error("wrap flag set while stopped");

  property p_period;
    (tick && !quad && !wr_cnt && count_q == cap_q[0])
      |=> (count_q == 16'h0000) && wrap_flag;
  endproperty
  a_period: assert property (p_period) // [R5]
    else $error("period match did not reload zero and flag");

  property p_quad_wrap;
    (tick && quad && !wr_cnt && count_q == 16'hffff)
      |=> (count_q == 16'h0000) && wrap_flag;
  endproperty
  a_quad_wrap: assert property (p_quad_wrap) // [R17]
    else $error("free-run wrap did not reach zero with flag");

  property p_step;
    (tick && !wrap_ev && !wr_cnt)
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_step: assert property (p_step) // [R2]
    else $error("counter did not advance by one on a tick");

  property p_ch1_off;
    (!quad && !cap_flag[0]) |=> !cap_flag[0];
  endproperty
  a_ch1_off: assert property (p_ch1_off) // [R7]
    else $error("channel one captured in period mode");

  property p_cap_value;
    take[1] |=> (cap_q[1] == $past(count_q)) && cap_flag[1];
  endproperty
  a_cap_value: assert property (p_cap_value) // [R9]
    else $error("capture did not hold counter value and flag");

  property p_timer_irq;
    1'b1 |=> timer_irq ==
      $past(wrap_flag && ctrl[tqc_pkg::CTL_WRAPEN]);
  endproperty
  a_timer_irq: assert property (p_timer_irq) // [R6]
    else $error("timer request does not follow flag and enable");

  property p_cap_irq;
    (ctrl[tqc_pkg::CTL_GDIS] || !ctrl[tqc_pkg::CTL_PERIPHERAL_IRQ_ENABLE]) |=> !capture_irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) // [R10]
    else $error("capture request despite global gating");
endmodule

// ### logic/tqc_pkg.sv
// shared constants for the timer three quad capture block
package tqc_pkg;
  localparam int  NUM_CH     = 4;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_EVSEL  = 8'h04;
  localparam logic [7:0] OFF_CAPEN  = 8'h08;
  localparam logic [7:0] OFF_FLAGS  = 8'h0c;
  localparam logic [7:0] OFF_OVR    = 8'h10;
  localparam logic [7:0] OFF_CNT_LO = 8'h14;
  localparam logic [7:0] OFF_CNT_HI = 8'h18;
  // capture low byte of channel n at OFF_CAP_LO + 8*n, high byte 4 above
  localparam logic [7:0] OFF_CAP_LO = 8'h1c;
  localparam logic [7:0] OFF_CAP_HI = 8'h20;
  localparam logic [7:0] CAP_STRIDE = 8'h08;
  // control register field positions
  localparam int  CTL_RUN    = 0;
  localparam int  CTL_SRC    = 1;
  localparam int  CTL_QUAD   = 2;
  localparam int  CTL_WRAPEN = 3;
  localparam int  CTL_PERIPHERAL_IRQ_ENABLE   = 4;
  localparam int  CTL_GDIS   = 5;
  localparam int  CTL_W      = 6;
  // flags register: bit 0 wrap flag, bits 4:1 capture flags
  localparam int  FLG_WRAP   = 0;
  localparam int  FLG_CAP    = 1;
  // reset values
  localparam logic [CTL_W-1:0] RST_CTRL  = 6'h00;
  localparam logic [7:0]       RST_EVSEL = 8'h00;
  localparam logic [15:0]      RST_COUNT = 16'h0000;
  // event select encodings
  localparam logic [1:0] EV_FALL   = 2'h0;
  localparam logic [1:0] EV_RISE   = 2'h1;
  localparam logic [1:0] EV_RISE4  = 2'h2;
  localparam logic [1:0] EV_RISE16 = 2'h3;
  // prescaler terminal counts
  localparam logic [1:0] PRE4_LAST  = 2'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### logic/tqc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module tqc_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end

  // change counts only once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      level <= 1'b0;
    else if (s2 == s3)
      level <= s3; // [R14]

  property p_filter;
    @(posedge hclk) disable iff (!hresetn)
    (s2 != s3) |=> $stable(level);
  endproperty
  a_filter: assert property (p_filter) // [R14]
    else $error("synchroniser level moved while stages disagree");
endmodule

// ### logic/tqc_chan.sv
// one capture channel: event select, prescaler, unread and overrun
`timescale 1ns/100ps
module tqc_chan (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       level,
  input  wire logic [1:0] sel,
  input  wire logic       active,
  input  wire logic       rd_lo,
  input  wire logic       rd_hi,
  output logic            take,
  output logic            overrun
);
  logic       prev;
  logic [3:0] pre;
  logic       unread;
  logic       lo_seen;
  logic       hi_seen;
  logic       master;
  logic       rise;
  logic       fall;
  logic       ev;
  logic       both;

  assign rise = level & ~prev;
  assign fall = ~level & prev;
  assign both = (rd_lo | lo_seen) & (rd_hi | hi_seen); // [R16]

  always_comb
  begin
    unique case (sel) // [R8] [R21]
      tqc_pkg::EV_FALL:  ev = fall;
      tqc_pkg::EV_RISE:  ev = rise;
      tqc_pkg::EV_RISE4: ev = rise & (pre[1:0] == tqc_pkg::PRE4_LAST);
      tqc_pkg::EV_RISE16: ev = rise & (pre == tqc_pkg::PRE16_LAST);
    endcase
  end

  // an unread word is protected from the next event
  assign take = ev & active & ~unread; // [R9] [R15]

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      prev <= 1'b0;
    else
      prev <= level;

  // prescaler ignores select changes; only reset clears it
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pre <= 4'h0;
    else if (rise)
      pre <= pre + 4'h1; // [R12]

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      lo_seen <= 1'b0;
      hi_seen <= 1'b0;
    end
    else if (both)
    begin
      lo_seen <= 1'b0;
      hi_seen <= 1'b0;
    end
    else
    begin
      lo_seen <= lo_seen | rd_lo;
      hi_seen <= hi_seen | rd_hi;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      unread <= 1'b0;
    else if (take)
      unread <= 1'b1; // [R22]
    else if (both)
      unread <= 1'b0; // [R22]

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      master <= 1'b0;
    else if (ev && active && unread)
      master <= 1'b1; // [R15]
    else if (both)
      master <= 1'b0; // [R16]

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      overrun <= 1'b0;
    else if (both)
      overrun <= master; // [R16]

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_protect;
    (ev && active && unread && !both) |=> (master && unread);
  endproperty
  a_protect: assert property (p_protect) // [R15]
    else $error("event on unread word did not raise master overrun");

  property p_transfer;
    both |=> (overrun == $past(master)) && (unread == $past(take));
  endproperty
  a_transfer: assert property (p_transfer) // [R16]
    else $error("overrun not copied after both bytes read");

  property p_rise16;
    (sel == tqc_pkg::EV_RISE16 && take) |-> (pre == tqc_pkg::PRE16_LAST);
  endproperty
  a_rise16: assert property (p_rise16) // [R8]
    else $error("sixteenth-edge capture at wrong prescaler count");
endmodule

// ### sim/tqc_pin_model.sv
// pin-side model: capture pins and the external count clock
`timescale 1ns/100ps
module tqc_pin_model (
  input  wire logic hclk,
  output logic      ext_count_clock_pin,
  output logic [3:0] capture_input_pin
);
  initial
  begin
    ext_count_clock_pin = 1'b1;
    capture_input_pin   = 4'h0;
  end

  // a pin used as a port output still reaches the capture logic
  task automatic pulse(input int ch);
    @(posedge hclk);
    capture_input_pin[ch] <= 1'b1;
    // six cycles high and seven low, above what the synchroniser can see
    repeat (6) @(posedge hclk);
    capture_input_pin[ch] <= 1'b0;
    repeat (7) @(posedge hclk);
  endtask

  // clock idles high between ticks; counter moves on the fall
  task automatic tick();
    @(posedge hclk);
    ext_count_clock_pin <= 1'b0;
    repeat (5) @(posedge hclk);
    ext_count_clock_pin <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// ### sim/tqc_tb.sv
// self-checking bench for the timer three quad capture block
`timescale 1ns/100ps
module testbench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_count_clock_pin;
  logic [3:0]  capture_input_pin;
  logic        timer_irq;
  logic        capture_irq;
  int          fail_count;
  int          comparisons;
  logic [15:0] mcount;
  logic [15:0] cap [4];
  logic [3:0]  pre [4];
  logic [3:0]  unread;
  logic [3:0]  master;
  logic [3:0]  ovr;
  logic [4:0]  flags;
  logic [5:0]  ctrl;
  logic [7:0]  evsel;
  logic [31:0] r;

  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  tqc_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_count_clock_pin(ext_count_clock_pin),
    .capture_input_pin(capture_input_pin), .timer_irq(timer_irq),
    .capture_irq(capture_irq)
  );

  tqc_pin_model pins (
    .hclk(hclk), .ext_count_clock_pin(ext_count_clock_pin),
    .capture_input_pin(capture_input_pin)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= tqc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(r, e);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic setc(input logic [5:0] v);
    wr(tqc_pkg::OFF_CTRL, {26'h0, v});
    ctrl = v;
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(tqc_pkg::OFF_CNT_LO, {24'h0, v[7:0]});
    wr(tqc_pkg::OFF_CNT_HI, {24'h0, v[15:8]});
    mcount = v;
  endtask

  task automatic clrflags();
    wr(tqc_pkg::OFF_FLAGS, 32'h1f);
    flags = 5'h0;
  endtask

  function automatic logic [7:0] caddr(input int ch, input logic hi);
    return tqc_pkg::OFF_CAP_LO + tqc_pkg::CAP_STRIDE * 8'(ch)
           + (hi ? 8'h04 : 8'h00);
  endfunction

  task automatic ev(input int ch);
    if (ch != 0 || ctrl[tqc_pkg::CTL_QUAD])
    begin
      if (unread[ch])
        master[ch] = 1'b1;
      else
      begin
        cap[ch] = mcount;
        unread[ch] = 1'b1;
        flags[ch+1] = 1'b1;
      end
    end
  endtask

  // the prescaler counts every rising edge whatever the select
  task automatic pulse(input int ch);
    logic [1:0] s;
    s = evsel[2*ch +: 2];
    pins.pulse(ch);
    if (s == tqc_pkg::EV_RISE
        || (s == tqc_pkg::EV_RISE4 && pre[ch][1:0] == 2'h3)
        || (s == tqc_pkg::EV_RISE16 && pre[ch] == 4'hf))
      ev(ch);
    pre[ch] = pre[ch] + 4'h1;
    if (s == tqc_pkg::EV_FALL)
      ev(ch);
  endtask

  task automatic rdcap(input int ch);
    rd(caddr(ch, 1'b0), {24'h0, cap[ch][7:0]});
    rd(caddr(ch, 1'b1), {24'h0, cap[ch][15:8]});
    ovr[ch] = master[ch];
    master[ch] = 1'b0;
    unread[ch] = 1'b0;
    rd(tqc_pkg::OFF_OVR, {28'h0, ovr});
  endtask

  task automatic tick();
    pins.tick();
    if (ctrl[tqc_pkg::CTL_RUN] && ctrl[tqc_pkg::CTL_SRC])
    begin
      if (!ctrl[tqc_pkg::CTL_QUAD] && mcount == cap[0])
        mcount = 16'h0;
      else
        mcount = mcount + 16'h1;
      if (mcount == 16'h0)
        flags[0] = 1'b1;
    end
  endtask

  task automatic count_run(input logic [5:0] c, input int n);
    setc(c);
    repeat (n) tick();
    setc(c & 6'h3e);
    rd(tqc_pkg::OFF_CNT_LO, {24'h0, mcount[7:0]});
    rd(tqc_pkg::OFF_CNT_HI, {24'h0, mcount[15:8]});
    rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fail_count = 0;
    comparisons = 0;
    mcount = 16'h0;
    unread = 4'h0;
    master = 4'h0;
    ovr = 4'h0;
    flags = 5'h0;
    ctrl = 6'h0;
    evsel = 8'h0;
    for (int i = 0; i < 4; i++)
    begin
      cap[i] = 16'h0;
      pre[i] = 4'h0;
    end
    void'($urandom(47342));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // every place reads zero after reset, 0x3c is unmapped
    for (int a = 0; a <= 8'h3c; a += 4) rd(8'(a), 32'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    // byte-sized write is refused, select register keeps zero
    hsize <= 3'h0;
    wr(tqc_pkg::OFF_EVSEL, 32'hff);
    hsize <= 3'h2;
    rd(tqc_pkg::OFF_EVSEL, 32'h0);
    setcnt(16'($urandom));
    count_run(6'h02, 3);
    wr(caddr(0, 1'b0), 32'h03);
    wr(caddr(0, 1'b1), 32'h00);
    cap[0] = 16'h0003;
    setcnt(16'h0000);
    count_run(6'h0b, 5);
    check({31'h0, timer_irq}, 32'h1);
    setc(6'h02);
    rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
    check({31'h0, timer_irq}, 32'h0);
    clrflags();
    rd(tqc_pkg::OFF_FLAGS, 32'h0);
    setcnt(16'hfffe);
    count_run(6'h07, 3);
    // internal source: zero-wait bus leaves run up for three clocks
    setc(6'h05);
    setc(6'h04);
    mcount = mcount + 16'h0003;
    rd(tqc_pkg::OFF_CNT_LO, {24'h0, mcount[7:0]});
    rd(tqc_pkg::OFF_CNT_HI, {24'h0, mcount[15:8]});
    // four-capture mode, one select code per channel
    setc(6'h04);
    evsel = 8'he4;
    wr(tqc_pkg::OFF_EVSEL, {24'h0, evsel});
    clrflags();
    for (int ch = 0; ch < 4; ch++)
    begin
      for (int k = 0; k < ((ch == 2) ? 6 : 16); k++)
      begin
        if (k < 2)
          setcnt(16'($urandom));
        pulse(ch);
      end
      rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
      rdcap(ch);
      rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
    end
    wr(tqc_pkg::OFF_CAPEN, 32'hf);
    setc(6'h14);
    repeat (2) @(posedge hclk);
    check({31'h0, capture_irq}, {31'h0, |flags[4:1]});
    setc(6'h34);
    repeat (2) @(posedge hclk);
    check({31'h0, capture_irq}, 32'h0);
    // channel three moves to every 16th with its prescaler part way
    evsel = 8'hf4;
    wr(tqc_pkg::OFF_EVSEL, {24'h0, evsel});
    clrflags();
    for (int k = 0; k < 10; k++)
    begin
      pulse(2);
      rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
    end
    // period mode leaves channel one idle
    setc(6'h00);
    clrflags();
    cap[0] = 16'($urandom);
    wr(caddr(0, 1'b0), {24'h0, cap[0][7:0]});
    wr(caddr(0, 1'b1), {24'h0, cap[0][15:8]});
    setcnt(16'($urandom));
    pulse(0);
    rd(tqc_pkg::OFF_FLAGS, {27'h0, flags});
    rd(caddr(0, 1'b0), {24'h0, cap[0][7:0]});
    rd(caddr(0, 1'b1), {24'h0, cap[0][15:8]});
    print_verdict();
  end
endmodule
